// ### core/fsg_host.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module fsg_host (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [3:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   output logic irq,
   output var fsg_pkg::fsg_pins_t pins,
   input wire logic [7:0] dq_in,
   input wire logic ready_busy_out
);
   import fsg_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_PD, S_WAKE, S_STEP, S_WL, S_WH, S_RL, S_RS} fsg_state_t;

   fsg_state_t state_r; // sequencer state
   logic [2:0] op_r; // operation in progress
   logic [2:0] step_r; // step within the operation
   logic pd_req_r; // software asks for deep powerdown
   logic [ADDR_W-1:0] addr_r; // target address
   logic [7:0] wdata_r; // byte to program
   logic [7:0] flash_stat_r; // last device status seen
   logic [7:0] rdata_r; // last array byte read
   logic retry_r; // aborted write or erase awaits replay
   logic [7:0] wake_cnt_r; // cycles spent waking
   logic [ADDR_W-1:0] pin_addr_r; // address pins
   logic [7:0] pin_dq_r; // data pins
   logic [IRQ_W-1:0] irq_stat_r; // sticky events
   logic [IRQ_W-1:0] irq_mask_r; // event enables
   logic [7:0] last_byte_r; // last byte strobed into the device
   logic [7:0] since_wake_r; // cycles since the powerdown pin rose
   fsg_act_t act; // current step's bus action
   logic active; // state that is touching the bus
   logic cmd_wr; // software writes the command register
   logic refuse; // write or erase refused
   logic cmd_go; // operation accepted
   logic ev_done;
   logic ev_err;
   logic ev_abort;
   logic poll_op;

   // what each operation does at each step
   function automatic fsg_act_t step_act(input logic [2:0] op, input logic [2:0] step, input logic [7:0] data);
      fsg_act_t a;
      a = '{kind: ACT_END, val: CMD_READ_ARRAY};
      unique case (op)
         OP_READ: begin
            // array reads always follow a fresh read-array command
            if (step == 3'h0) a = '{kind: ACT_WRITE, val: CMD_READ_ARRAY};
            else if (step == 3'h1) a.kind = ACT_READ;
         end
         OP_WRITE, OP_ERASE: begin
            if (step == 3'h0) a = '{kind: ACT_WRITE, val: (op == OP_WRITE) ? CMD_WRITE_SETUP : CMD_ERASE_SETUP};
            else if (step == 3'h1) a = '{kind: ACT_WRITE, val: (op == OP_WRITE) ? data : CMD_ERASE_CONFIRM};
            else if (step == 3'h2) a.kind = ACT_POLL;
            else if (step == 3'h3) a = '{kind: ACT_WRITE, val: CMD_READ_ARRAY};
         end
         OP_CLEAR: begin
            if (step == 3'h0) a = '{kind: ACT_WRITE, val: CMD_CLEAR_STATUS};
         end
         OP_STAT: begin
            if (step == 3'h0) a = '{kind: ACT_WRITE, val: CMD_READ_STATUS};
            else if (step == 3'h1) a.kind = ACT_READ;
            else if (step == 3'h2) a = '{kind: ACT_WRITE, val: CMD_READ_ARRAY};
         end
         default: a.kind = ACT_END;
      endcase
      return a;
   endfunction : step_act

   assign act = step_act(op_r, step_r, wdata_r);
   assign active = (state_r == S_STEP) || (state_r == S_WL) || (state_r == S_WH) ||
                   (state_r == S_RL) || (state_r == S_RS);
   assign poll_op = (op_r == OP_WRITE) || (op_r == OP_ERASE);
   assign cmd_wr = clk_en && bus_wr && (bus_addr == REG_CMD);
   // the host will not start a write or erase while the device reports low program voltage
   assign refuse = cmd_wr && (state_r == S_IDLE) && !pd_req_r && flash_stat_r[SR_VPP_LOW] &&
                   ((bus_wdata[2:0] == OP_WRITE) || (bus_wdata[2:0] == OP_ERASE));
   assign cmd_go = cmd_wr && (state_r == S_IDLE) && !pd_req_r && !refuse &&
                   (bus_wdata[2:0] >= OP_READ) && (bus_wdata[2:0] <= OP_STAT);
   assign ev_done = clk_en && (state_r == S_STEP) && (act.kind == ACT_END);
   // any error flag after a programming operation, including the double flag of a bad sequence
   assign ev_err = ev_done && poll_op && (flash_stat_r[SR_ERASE_ERR:SR_VPP_LOW] != 3'h0);
   assign ev_abort = clk_en && pd_req_r && active;

   // sequencer; powerdown request pre-empts everything
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
      end else if (clk_en) begin
         if (pd_req_r && state_r != S_PD) begin
            state_r <= S_PD;
         end else begin
            unique case (state_r)
               S_IDLE: if (cmd_go) state_r <= S_STEP;
               S_PD: if (!pd_req_r) state_r <= S_WAKE;
               // no access until both wakeup waits have passed
               S_WAKE: if (wake_cnt_r == WAKE_CYC - 8'h01) state_r <= retry_r ? S_STEP : S_IDLE;
               S_STEP: begin
                  unique case (act.kind)
                     ACT_WRITE: state_r <= S_WL;
                     ACT_READ, ACT_POLL: state_r <= S_RL;
                     ACT_END: state_r <= S_IDLE;
                  endcase
               end
               S_WL: state_r <= S_WH;
               S_WH: state_r <= S_STEP;
               S_RL: state_r <= S_RS;
               S_RS: state_r <= S_STEP;
            endcase
         end
      end
   end

   // step counter; a poll step repeats until the device reports ready
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_r <= 3'h0;
      end else if (clk_en) begin
         if (cmd_go || state_r == S_WAKE) step_r <= 3'h0;
         else if (state_r == S_WH) step_r <= step_r + 3'h1;
         else if (state_r == S_RS && !(act.kind == ACT_POLL && !dq_in[SR_READY])) step_r <= step_r + 3'h1;
      end
   end

   // a write or erase cut short by powerdown is replayed from its first step
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         retry_r <= 1'b0;
      end else if (clk_en) begin
         if (ev_abort && poll_op) retry_r <= 1'b1;
         else if (state_r == S_WAKE && wake_cnt_r == WAKE_CYC - 8'h01) retry_r <= 1'b0;
      end
   end

   // wakeup counter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) wake_cnt_r <= 8'h00;
      else if (clk_en) wake_cnt_r <= (state_r == S_WAKE) ? wake_cnt_r + 8'h01 : 8'h00;
   end

   // shadow of the device status byte
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_stat_r <= SR_RESET;
      end else if (clk_en) begin
         if (state_r == S_PD) flash_stat_r <= SR_RESET;
         else if (state_r == S_RS && (act.kind == ACT_POLL || op_r == OP_STAT)) flash_stat_r <= dq_in;
         else if (state_r == S_WH && op_r == OP_CLEAR) flash_stat_r <= flash_stat_r & SR_CLEAR_MASK;
      end
   end

   // array read result
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rdata_r <= 8'h00;
      else if (clk_en && state_r == S_RS && op_r == OP_READ) rdata_r <= dq_in;
   end

   // address and data pins load as each step starts, so they settle before the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_addr_r <= '0;
         pin_dq_r <= 8'h00;
      end else if (clk_en && state_r == S_STEP) begin
         pin_addr_r <= addr_r;
         pin_dq_r <= act.val;
      end
   end

   // control pins: we only pulses with ce low; everything quiet while reset is low
   always_comb begin
      pins.reset_powerdown_n = (state_r != S_PD);
      pins.ce_n = !((state_r == S_WL) || (state_r == S_WH) || (state_r == S_RL) || (state_r == S_RS));
      pins.we_n = (state_r != S_WL);
      pins.oe_n = !((state_r == S_RL) || (state_r == S_RS));
      pins.dq_oe_n = !((state_r == S_WL) || (state_r == S_WH)); // data held one cycle past we rising
      pins.addr = pin_addr_r;
      pins.dq_out = pin_dq_r;
   end

   // software writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pd_req_r <= 1'b0;
         addr_r <= '0;
         wdata_r <= 8'h00;
         op_r <= OP_READ;
         irq_mask_r <= '0;
      end else if (clk_en && bus_wr) begin
         unique case (bus_addr)
            REG_CTRL: pd_req_r <= bus_wdata[CTRL_PD_BIT];
            // target and data are frozen while an operation runs
            REG_ADDR: if (state_r == S_IDLE) addr_r <= bus_wdata[ADDR_W-1:0];
            REG_WDATA: if (state_r == S_IDLE) wdata_r <= bus_wdata[7:0];
            REG_CMD: if (cmd_go) op_r <= bus_wdata[2:0];
            REG_IRQ_MASK: irq_mask_r <= bus_wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // sticky events; a read clears, but an event in the same cycle survives
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= '0;
      end else if (clk_en) begin
         irq_stat_r <= ((bus_rd && bus_addr == REG_IRQ_STAT) ? '0 : irq_stat_r) |
                       {ev_abort, refuse, ev_err, ev_done};
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         bus_rdata <= 32'h0000_0000;
         if (bus_rd) begin
            unique case (bus_addr)
               REG_CTRL: bus_rdata[CTRL_PD_BIT] <= pd_req_r;
               REG_ADDR: bus_rdata[ADDR_W-1:0] <= addr_r;
               REG_WDATA: bus_rdata[7:0] <= wdata_r;
               REG_CMD: bus_rdata[2:0] <= op_r;
               REG_STATUS: bus_rdata[ST_RETRY_BIT:0] <= {retry_r, ready_busy_out, state_r == S_PD,
                                                        state_r != S_IDLE && state_r != S_PD, flash_stat_r};
               REG_RDATA: bus_rdata[7:0] <= rdata_r;
               REG_IRQ_STAT: bus_rdata[IRQ_W-1:0] <= irq_stat_r;
               REG_IRQ_MASK: bus_rdata[IRQ_W-1:0] <= irq_mask_r;
               default: ;
            endcase
         end
      end
   end

   // helper state for the checks below
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_byte_r <= CMD_READ_ARRAY;
         since_wake_r <= 8'hFF;
      end else begin
         if (!pins.we_n) last_byte_r <= pins.dq_out;
         if (!pins.reset_powerdown_n) since_wake_r <= 8'h00;
         else if (since_wake_r != 8'hFF) since_wake_r <= since_wake_r + 8'h01;
      end
   end

   property p_we_gated;
      @(posedge mclk) disable iff (rst)
         !pins.we_n |-> !pins.ce_n && pins.oe_n && pins.reset_powerdown_n && !pins.dq_oe_n;
   endproperty
   a_we_gated: assert property (p_we_gated) else $error("write strobe without chip enable");
   property p_pd_quiet;
      @(posedge mclk) disable iff (rst)
         !pins.reset_powerdown_n |-> pins.ce_n && pins.we_n && pins.oe_n && pins.dq_oe_n;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("controls active during powerdown");
   property p_wake;
      @(posedge mclk) disable iff (rst) !pins.ce_n |-> since_wake_r >= WAKE_CYC;
   endproperty
   a_wake: assert property (p_wake) else $error("access before wakeup interval");
   property p_refuse;
      @(posedge mclk) disable iff (rst) refuse |=> state_r == S_IDLE && irq_stat_r[IRQ_REFUSED];
   endproperty
   a_refuse: assert property (p_refuse) else $error("write or erase started with vpp low");
   property p_final_ff;
      @(posedge mclk) disable iff (rst) ev_done && poll_op |-> last_byte_r == CMD_READ_ARRAY;
   endproperty
   a_final_ff: assert property (p_final_ff) else $error("operation ended without read-array");
   property p_read_ff;
      @(posedge mclk) disable iff (rst)
         $fell(pins.oe_n) && op_r == OP_READ |-> last_byte_r == CMD_READ_ARRAY;
   endproperty
   a_read_ff: assert property (p_read_ff) else $error("array read without read-array");
   property p_no_contention;
      @(posedge mclk) disable iff (rst) !pins.dq_oe_n |-> pins.oe_n ##1 (pins.oe_n || pins.dq_oe_n);
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("host and device drive data together");
   property p_retry;
      @(posedge mclk) disable iff (rst || !clk_en)
         $rose(pins.reset_powerdown_n) && retry_r |-> ##[1:20] !pins.we_n;
   endproperty
   a_retry: assert property (p_retry) else $error("aborted sequence not replayed");

endmodule : fsg_host

`default_nettype wire

// ### include/fsg_pkg.sv
package fsg_pkg;

   // bus clock period and host-side wakeup waits after powerdown exit
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned READ_WAKEUP_NS = 400; // read_wakeup_interval
   localparam int unsigned WRITE_WAKEUP_NS = 1000; // write_wakeup_interval, plain default
   localparam int unsigned READ_WAKEUP_CYC = (READ_WAKEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_WAKEUP_CYC = (WRITE_WAKEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // one wait covers both, since the next step may be either a read or a write
   localparam logic [7:0] WAKE_CYC = 8'((READ_WAKEUP_CYC > WRITE_WAKEUP_CYC) ? READ_WAKEUP_CYC : WRITE_WAKEUP_CYC);

   // software register offsets on the host command port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_CMD = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RDATA = 4'h5;
   localparam logic [3:0] REG_IRQ_STAT = 4'h6;
   localparam logic [3:0] REG_IRQ_MASK = 4'h7;

   // field positions
   localparam int unsigned CTRL_PD_BIT = 0;
   localparam int unsigned ST_BUSY_BIT = 8;
   localparam int unsigned ST_PD_BIT = 9;
   localparam int unsigned ST_RB_BIT = 10;
   localparam int unsigned ST_RETRY_BIT = 11;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_ERR = 1;
   localparam int unsigned IRQ_REFUSED = 2;
   localparam int unsigned IRQ_ABORT = 3;
   localparam int unsigned IRQ_W = 4;

   // device status byte layout and its value after powerdown
   localparam int unsigned SR_READY = 7;
   localparam int unsigned SR_ERASE_ERR = 5;
   localparam int unsigned SR_WRITE_ERR = 4;
   localparam int unsigned SR_VPP_LOW = 3;
   localparam logic [7:0] SR_RESET = 8'h80;
   localparam logic [7:0] SR_CLEAR_MASK = 8'hC7;

   // device command bytes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;

   // host operation codes written to REG_CMD
   localparam logic [2:0] OP_READ = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_ERASE = 3'h3;
   localparam logic [2:0] OP_CLEAR = 3'h4;
   localparam logic [2:0] OP_STAT = 3'h5;

   localparam int unsigned ADDR_W = 20;

   typedef enum logic [1:0] {ACT_WRITE, ACT_READ, ACT_POLL, ACT_END} fsg_act_kind_t;

   typedef struct packed {
      fsg_act_kind_t kind;
      logic [7:0] val;
   } fsg_act_t;

   // every pin the host drives toward the device
   typedef struct packed {
      logic reset_powerdown_n;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0] dq_out;
   } fsg_pins_t;

endpackage : fsg_pkg

// ### verif/fsg_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural byte-wide flash seen from the host pins; no clock of its own
module fsg_flash_model
   import fsg_pkg::*;
(
   input wire fsg_pkg::fsg_pins_t pins,
   input wire logic [31:0] busy_ns,
   input wire logic inject_err,
   input wire logic vpp_low,
   output logic [7:0] dq_in,
   output logic ready_busy_out
);
   logic [7:0] mem [0:255]; // 16 blocks of 16 bytes stand in for the array
   logic [7:0] sr = SR_RESET; // status byte
   logic array_mode = 1'b1; // read-array versus read-status
   logic [1:0] pend = 2'd0; // 1 write setup, 2 erase setup
   int op_id = 0; // bumped on abort so a stale completion is dropped
   logic [7:0] p_idx = 8'h00;
   logic [7:0] p_dat = 8'h00;
   logic p_erase = 1'b0;
   logic [7:0] last_v = 8'h00; // last byte driven, for the released bus
   wire logic drv = pins.reset_powerdown_n && !pins.ce_n && !pins.oe_n;
   wire logic [7:0] rd_val = array_mode ? mem[{pins.addr[19:16], pins.addr[3:0]}] : sr;

   initial foreach (mem[i]) mem[i] = 8'hFF;
   assign ready_busy_out = sr[SR_READY];
   // a released bus shows the inverse so stale data never passes for valid
   always @(rd_val or drv) if (drv) last_v = rd_val;
   assign dq_in = drv ? rd_val : ~last_v;

   // end of the internal algorithm; an abort leaves the target half done
   task automatic finish_op(input logic aborted);
      int i;
      if (!aborted && inject_err) sr[p_erase ? SR_ERASE_ERR : SR_WRITE_ERR] = 1'b1;
      else if (p_erase) for (i = 0; i < 16; i++) mem[{p_idx[7:4], i[3:0]}] = aborted ? 8'h0F : 8'hFF;
      else mem[p_idx] = mem[p_idx] & (aborted ? (p_dat | 8'h0F) : p_dat);
      sr[SR_READY] = 1'b1;
   endtask : finish_op

   task automatic start_busy();
      int id;
      id = op_id;
      sr[SR_READY] = 1'b0;
      fork
         begin
            #(busy_ns);
            if (id == op_id) finish_op(1'b0);
         end
      join_none
   endtask : start_busy

   // powerdown: abort, status back to ready only, read-array mode
   always @(negedge pins.reset_powerdown_n) begin
      if (!sr[SR_READY]) finish_op(1'b1);
      op_id++;
      sr = SR_RESET;
      array_mode = 1'b1;
      pend = 2'd0;
   end

   // command latch: taken on the rising write strobe while selected and awake
   always @(posedge pins.we_n) begin : cmd
      logic [1:0] was;
      was = pend;
      if (pins.reset_powerdown_n === 1'b1 && pins.ce_n === 1'b0) begin
         pend = 2'd0;
         if (was != 2'd0) begin
            array_mode = 1'b0;
            if (was == 2'd1 || pins.dq_out == CMD_ERASE_CONFIRM) begin
               p_erase = (was == 2'd2);
               p_idx = {pins.addr[19:16], pins.addr[3:0]};
               p_dat = pins.dq_out;
               if (vpp_low || sr[SR_VPP_LOW]) sr[SR_VPP_LOW] = 1'b1;
               else start_busy();
            end else sr[SR_ERASE_ERR:SR_WRITE_ERR] = 2'b11;
         end else if (pins.dq_out == CMD_READ_ARRAY) array_mode = 1'b1;
         else if (pins.dq_out == CMD_CLEAR_STATUS) sr = sr & SR_CLEAR_MASK;
         else begin
            array_mode = 1'b0;
            if (pins.dq_out == CMD_WRITE_SETUP) pend = 2'd1;
            if (pins.dq_out == CMD_ERASE_SETUP) pend = 2'd2;
         end
      end
   end
endmodule : fsg_flash_model
`default_nettype wire

// ### verif/flash_status_power_guard_tb.sv
`timescale 1ns/1ns
`default_nettype none
module flash_status_power_guard_tb;
   import fsg_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] bus_addr = 4'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic [31:0] bus_rdata;
   logic irq;
   fsg_pins_t pins;
   logic [7:0] dq_in;
   logic ready_busy_out;
   logic [31:0] busy_ns = 32'd2000; // device algorithm time
   logic inject_err = 1'b0;
   logic vpp_low = 1'b0;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   int we_cnt = 0; // write strobes seen on the device pin
   int wake_cnt = 255; // cycles since the device woke
   logic [31:0] s;

   fsg_host dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .pins(pins), .dq_in(dq_in),
      .ready_busy_out(ready_busy_out));
   fsg_flash_model flash (.pins(pins), .busy_ns(busy_ns), .inject_err(inject_err), .vpp_low(vpp_low),
      .dq_in(dq_in), .ready_busy_out(ready_busy_out));

   initial forever #50 mclk = ~mclk;

   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe is taken
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // poll busy with a bound; the last status word stays in s
   task automatic wait_idle();
      int n;
      for (n = 0; n < 600; n++) begin
         rd(REG_STATUS, s);
         if (s[ST_BUSY_BIT] === 1'b0) break;
      end
      chk(n < 600, 1, "operation never finished");
   endtask : wait_idle

   // start an operation and wait for it to finish
   task automatic run_op(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d);
      wr(REG_ADDR, {12'h0, a});
      wr(REG_WDATA, {24'h0, d});
      wr(REG_CMD, {29'h0, op});
      wait_idle();
   endtask : run_op

   task automatic t_write();
      run_op(OP_WRITE, 20'h30005, 8'h5A);
      chk(flash.array_mode, 1'b1, "device left in status mode");
      run_op(OP_READ, 20'h30005, 8'h00);
      rd(REG_RDATA, s);
      chk(s[7:0], 8'h5A, "array byte");
   endtask : t_write

   task automatic t_error();
      wr(REG_IRQ_MASK, 32'h2);
      rd(REG_IRQ_STAT, s);
      inject_err = 1'b1;
      run_op(OP_WRITE, 20'h30006, 8'h00);
      chk(s[7:0], 8'h90, "write error flag");
      chk(irq, 1'b1, "error interrupt");
      rd(REG_IRQ_STAT, s);
      chk(s[3:0], 4'h3, "done and error events");
      chk(irq, 1'b0, "interrupt after read clear");
      run_op(OP_ERASE, 20'h30000, 8'h00);
      chk(s[7:0], 8'hB0, "erase error flag");
      inject_err = 1'b0;
      run_op(OP_CLEAR, 20'h0, 8'h00);
      chk(s[7:0], SR_RESET, "status after clear");
   endtask : t_error

   task automatic t_vpp();
      int n;
      vpp_low = 1'b1;
      run_op(OP_WRITE, 20'h30007, 8'h33);
      chk(s[7:0], 8'h88, "program voltage low flag");
      rd(REG_IRQ_STAT, s);
      n = we_cnt;
      wr(REG_CMD, {29'h0, OP_WRITE});
      repeat (3) @(posedge mclk);
      chk(we_cnt, n, "write issued while flag set");
      rd(REG_IRQ_STAT, s);
      chk(s[3:0], 4'h4, "refused event");
      vpp_low = 1'b0;
      run_op(OP_CLEAR, 20'h0, 8'h00);
      run_op(OP_ERASE, 20'h30000, 8'h00);
      run_op(OP_READ, 20'h30005, 8'h00);
      rd(REG_RDATA, s);
      chk(s[7:0], 8'hFF, "erased byte");
      run_op(OP_STAT, 20'h0, 8'h00);
      chk(s[7:0], SR_RESET, "status after erase");
   endtask : t_vpp

   task automatic t_powerdown();
      busy_ns = 32'd20000;
      wr(REG_ADDR, 32'h20001);
      wr(REG_WDATA, 32'h3C);
      wr(REG_CMD, {29'h0, OP_WRITE});
      repeat (20) @(posedge mclk);
      chk(flash.sr[SR_READY], 1'b0, "algorithm running");
      wr(REG_CTRL, 32'h1);
      // the status shadow returns to its reset value one cycle after powerdown starts
      @(posedge mclk);
      rd(REG_STATUS, s);
      chk(pins.reset_powerdown_n, 1'b0, "powerdown pin");
      chk(s & 32'hEFF, 32'hE80, "status in powerdown");
      chk(flash.mem[8'h21], 8'h3F, "aborted byte partly written");
      repeat (5) @(posedge mclk);
      chk({pins.ce_n, pins.we_n, pins.oe_n}, 3'h7, "controls while powered down");
      busy_ns = 32'd300;
      wr(REG_CTRL, 32'h0);
      // the aborted write is replayed after the wakeup wait, and commands are ignored until then
      wait_idle();
      chk(s[ST_RETRY_BIT], 1'b0, "replay still pending");
      run_op(OP_READ, 20'h20001, 8'h00);
      rd(REG_RDATA, s);
      chk(s[7:0], 8'h3C, "replayed write");
      rd(REG_IRQ_STAT, s);
      chk(s[IRQ_ABORT], 1'b1, "abort event");
   endtask : t_powerdown

   // watchdog, strobe count and wakeup spacing on the device pins
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         report_and_stop();
      end
      if (!pins.reset_powerdown_n) wake_cnt = 0;
      else if (wake_cnt < 255) wake_cnt++;
      if (!pins.ce_n && wake_cnt < int'(WAKE_CYC)) chk(0, 1, "access inside wakeup time");
   end
   always @(negedge pins.we_n) we_cnt++;

   // reset leaves every device control idle and the status shadow at ready only
   task automatic t_reset();
      @(posedge mclk);
      chk({pins.reset_powerdown_n, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n}, 5'h1F,
          "pins after reset");
      rd(REG_STATUS, s);
      chk(s, 32'h480, "status after reset");
   endtask : t_reset

   // a low clock enable freezes the block, so a register write in that time is lost
   task automatic t_freeze();
      @(posedge mclk);
      clk_en <= 1'b0;
      wr(REG_IRQ_MASK, 32'hF);
      clk_en <= 1'b1;
      rd(REG_IRQ_MASK, s);
      chk(s, 32'h2, "mask written while frozen");
   endtask : t_freeze

   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_write();
      t_error();
      t_vpp();
      t_powerdown();
      t_freeze();
      report_and_stop();
   end
endmodule : flash_status_power_guard_tb
`default_nettype wire
